// File: cpcs_pkg.sv
package cpcs_pkg;

	// Widths and stack depth of the datapath
	localparam int DATA_W      = 32;
	localparam int STACK_DEPTH = 5;
	localparam int PTR_W       = 8;
	localparam int ADDR_W      = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_NEXT   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RETURN = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_HALT   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STACK  = 8'h20;

	// Field positions
	localparam int CMD_ALT_BIT    = 8;
	localparam int ST_EXEC_LSB    = 0;
	localparam int ST_SHIFT_BIT   = 2;
	localparam int ST_NUM_BIT     = 3;
	localparam int ST_WARN_BIT    = 4;
	localparam int ST_HALTIN_BIT  = 5;
	localparam int ST_PEND_BIT    = 6;
	localparam int ST_RETV_BIT    = 7;
	localparam int RET_VALID_BIT  = 31;

	// Reset values and AXI response codes
	localparam logic [PTR_W-1:0]  RST_PTR   = 8'h00;
	localparam logic [DATA_W-1:0] RST_LEVEL = 32'h0000_0000;
	localparam logic [1:0]        RESP_OK   = 2'h0;
	localparam logic [1:0]        RESP_ERR  = 2'h2;

	typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_STEP} cpcs_exec_type;

	typedef enum logic [4:0] {
		OP_NOP, OP_DIGIT, OP_ENTER, OP_START, OP_STEP, OP_STOP, OP_RUN, OP_PAUSE,
		OP_SHIFT, OP_CLEAR_SHIFT, OP_CLEAR_STACK, OP_CLEAR_BOTTOM, OP_ROLL, OP_SWAP,
		OP_RETURN, OP_ACQUIRE, OP_OTHER
	} cpcs_op_type;

	typedef logic [STACK_DEPTH-1:0][DATA_W-1:0] cpcs_stack_type;

	typedef struct packed {
		logic              valid;
		cpcs_op_type       op;
		logic              from_prog;
		logic              has_alt;
		logic [DATA_W-1:0] data;
	} cpcs_cmd_type;

	typedef struct packed {
		logic        warn;
		logic        abort_acq;
		logic        cancel_bus;
		logic        flush_buf;
		logic        alt_valid;
		cpcs_op_type alt_op;
	} cpcs_evt_type;

	typedef struct packed {
		cpcs_exec_type     exec;
		logic              shift;
		logic              numeric;
		logic              stop_pend;
		logic              halted_in;
		logic              warn_sticky;
		logic [PTR_W-1:0]  next_ptr;
		logic [PTR_W-1:0]  ret_ptr;
		logic              ret_valid;
		cpcs_op_type       last_op;
		cpcs_op_type       halt_op;
		cpcs_stack_type    stack;
		cpcs_evt_type      evt;
		logic              aw_rdy;
		logic              aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_rdy;
		logic              w_got;
		logic [DATA_W-1:0] w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              ar_rdy;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} cpcs_state_type;

endpackage

// File: cpcs_core.sv
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - Direct start enters Run, points at first command, clears return register.
// - Stored start in Step halts to idle, points at first command, clears return.
// - Stored start in Run stays Run from first command, clears return.
// - Single-step enters Step at the current next program command.
// - Single-step with edit pointer at end line warns and stays idle.
// - Single-step is accepted only when directly issued, never from a program.
// - Run, single-step and halt leave numeric entry open.
// - Direct halt while idle, with no command busy, also raises a warning.
// - Direct halt ends any realtime acquisition or averaging.
// - Direct halt cancels pending bus transfers and empties the command buffer.
// - Direct halt in a program finishes current command, then idles after it.
// - Halt shows executing command mnemonic plus halted-in flag when program interrupted.
// - Stored halt idles, next is following command, shows last command but halt/pause.
// - Shift command sets flag shown as indicator; clear-shift resets it.
// - Any other command clears shift; shifted key runs alternate or nothing.
// - Shifted key without alternate, or clear-shift, leaves numeric entry unchanged.
// - Clear-stack zeroes all five levels.
// - Clear-bottom pops; levels one to four take above, level five kept.
// - Enter ends numeric entry, else pushes up keeping level one.
// - Roll moves levels down by one, level five gets old level one.
// - Swap exchanges levels one and two at once.
// - Return takes next command from return register and clears its valid bit.
module cpcs_core
	import cpcs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire cpcs_cmd_type      cmd_in,
	input  wire logic              cmd_busy,
	input  wire logic              prog_stored,
	input  wire logic              edit_at_end,
	output cpcs_exec_type          exec_state,
	output logic [PTR_W-1:0]       next_ptr,
	output logic                   shift_ind,
	output logic                   halted_in,
	output cpcs_op_type            halt_op,
	output logic [DATA_W-1:0]      level_one,
	output cpcs_evt_type           evt,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// New stack value for a stack command, always from the old copy
	function automatic cpcs_stack_type stack_op(input cpcs_stack_type s, input cpcs_op_type op);
		cpcs_stack_type t;
		t = s;
		case (op)
			OP_CLEAR_STACK: begin
				for (int i = 0; i < STACK_DEPTH; i++) begin
					t[i] = RST_LEVEL;
				end
			end
			OP_CLEAR_BOTTOM: begin
				for (int i = 0; i < STACK_DEPTH-1; i++) begin
					t[i] = s[i+1];
				end
			end
			OP_ENTER: begin
				for (int i = 1; i < STACK_DEPTH; i++) begin
					t[i] = s[i-1];
				end
			end
			OP_ROLL: begin
				for (int i = 0; i < STACK_DEPTH-1; i++) begin
					t[i] = s[i+1];
				end
				t[STACK_DEPTH-1] = s[0];
			end
			OP_SWAP: begin
				t[0] = s[1];
				t[1] = s[0];
			end
			default: begin
				t = s;
			end
		endcase
		return t;
	endfunction

	// Commands that leave an open numeric entry untouched
	function automatic logic keeps_numeric(input cpcs_op_type op);
		case (op)
			OP_DIGIT, OP_RUN, OP_STEP, OP_STOP, OP_PAUSE, OP_SHIFT, OP_CLEAR_SHIFT: begin
				keeps_numeric = 1'b1;
			end
			default: begin
				keeps_numeric = 1'b0;
			end
		endcase
	endfunction

	// Byte-lane merge for partial AXI writes
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] d,
			input logic [3:0] strb);
		logic [DATA_W-1:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// Whether an address hits a word-aligned stack slot
	function automatic logic is_stack(input logic [ADDR_W-1:0] a);
		return (a >= OFS_STACK) && (a < OFS_STACK + ADDR_W'(4*STACK_DEPTH)) && (a[1:0] == 2'b00);
	endfunction

	cpcs_state_type r;
	cpcs_state_type n;
	cpcs_cmd_type   c;
	logic           bus_wr;
	logic           bus_cmd;
	logic [DATA_W-1:0] rd_word;
	logic           rd_hit;
	logic [2:0]     idx_w;
	logic [2:0]     idx_r;

	////////////////////////////////////////////////////////////////////////
	// Read decode

	always_comb begin
		idx_r   = 3'((s_axi_araddr - OFS_STACK) >> 2);
		rd_word = '0;
		rd_hit  = 1'b1;
		if (is_stack(s_axi_araddr)) begin
			rd_word = r.stack[idx_r];
		end else begin
			case (s_axi_araddr)
				OFS_CMD: begin
					rd_word = DATA_W'(r.last_op);
				end
				OFS_STATUS: begin
					rd_word[ST_EXEC_LSB +: 2] = r.exec;
					rd_word[ST_SHIFT_BIT]     = r.shift;
					rd_word[ST_NUM_BIT]       = r.numeric;
					rd_word[ST_WARN_BIT]      = r.warn_sticky;
					rd_word[ST_HALTIN_BIT]    = r.halted_in;
					rd_word[ST_PEND_BIT]      = r.stop_pend;
					rd_word[ST_RETV_BIT]      = r.ret_valid;
				end
				OFS_NEXT: begin
					rd_word[PTR_W-1:0] = r.next_ptr;
				end
				OFS_RETURN: begin
					rd_word[PTR_W-1:0]    = r.ret_ptr;
					rd_word[RET_VALID_BIT] = r.ret_valid;
				end
				OFS_HALT: begin
					rd_word = DATA_W'(r.halt_op);
				end
				default: begin
					rd_hit = 1'b0; // Unmapped reads answer SLVERR with zero data
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		n      = r;
		n.evt  = '0; // Event outputs are one-cycle pulses
		idx_w  = 3'((r.aw_addr - OFS_STACK) >> 2);

		// Write completes once both address and data are held
		bus_wr  = r.aw_got && r.w_got && !r.bvalid;
		bus_cmd = bus_wr && (r.aw_addr == OFS_CMD);
		// Keyboard wins the slot; a bus command waits, holding off bvalid
		if (bus_cmd && cmd_in.valid) begin
			bus_wr = 1'b0;
		end

		// Merge keyboard and bus controller into one command slot
		c = cmd_in;
		if (bus_cmd && bus_wr) begin
			c.valid     = 1'b1;
			c.op        = cpcs_op_type'(r.w_data[4:0]);
			c.from_prog = 1'b0;
			c.has_alt   = r.w_data[CMD_ALT_BIT];
			c.data      = RST_LEVEL;
		end

		// Deferred halt: current command has finished
		if (r.stop_pend && !cmd_busy) begin
			n.stop_pend = 1'b0;
			n.exec      = EX_IDLE;
			n.halted_in = 1'b1;
		end

		if (c.valid) begin
			if (r.shift && (c.op != OP_SHIFT)) begin
				// Shifted key: alternate function or nothing, numeric untouched
				n.shift = 1'b0;
				if ((c.op != OP_CLEAR_SHIFT) && c.has_alt) begin
					n.evt.alt_valid = 1'b1;
					n.evt.alt_op    = c.op;
				end
				// Numeric status deliberately left as is
			end else begin
				if (!keeps_numeric(c.op) && (c.op != OP_ENTER)) begin
					n.numeric = 1'b0;
				end
				if (c.from_prog && (c.op != OP_STEP)) begin
					n.next_ptr = r.next_ptr + PTR_W'(1); // Stored commands advance the pointer
					if (r.exec == EX_STEP) begin
						n.exec = EX_IDLE; // One line per single-step
					end
				end
				case (c.op)
					OP_SHIFT: begin
						n.shift = 1'b1;
					end
					OP_CLEAR_SHIFT: begin
						n.shift = 1'b0;
					end
					OP_DIGIT: begin
						n.stack[0] = c.data;
						n.numeric  = 1'b1;
					end
					OP_ENTER: begin
						if (r.numeric) begin
							n.numeric = 1'b0;
						end else begin
							n.stack = stack_op(r.stack, c.op);
						end
					end
					OP_CLEAR_STACK, OP_CLEAR_BOTTOM, OP_ROLL, OP_SWAP: begin
						n.stack = stack_op(r.stack, c.op);
					end
					OP_START: begin
						n.next_ptr  = RST_PTR;
						n.ret_valid = 1'b0;
						n.ret_ptr   = RST_PTR;
						if (!c.from_prog) begin
							// Sender guarantees a stored program
							n.exec      = EX_RUN;
							n.halted_in = 1'b0;
						end else if (r.exec == EX_STEP) begin
							n.exec = EX_IDLE;
						end else begin
							n.exec = r.exec;
						end
					end
					OP_STEP: begin
						if (c.from_prog) begin
							n.evt.warn = 1'b1;
						end else if (edit_at_end) begin
							n.evt.warn = 1'b1;
						end else begin
							n.exec      = EX_STEP;
							n.halted_in = 1'b0;
						end
					end
					OP_RUN: begin
						if (!c.from_prog) begin
							if (prog_stored && !edit_at_end) begin
								n.exec      = EX_RUN;
								n.halted_in = 1'b0;
							end else begin
								n.evt.warn = 1'b1;
							end
						end
					end
					OP_STOP: begin
						if (c.from_prog) begin
							n.exec      = EX_IDLE;
							n.halted_in = 1'b1;
							n.halt_op   = r.last_op;
						end else begin
							n.evt.abort_acq  = 1'b1;
							n.evt.cancel_bus = 1'b1;
							n.evt.flush_buf  = 1'b1;
							n.halt_op        = r.last_op;
							if ((r.exec == EX_IDLE) && !cmd_busy) begin
								n.evt.warn = 1'b1;
							end else if (r.exec != EX_IDLE) begin
								if (cmd_busy) begin
									n.stop_pend = 1'b1;
								end else begin
									n.exec      = EX_IDLE;
									n.halted_in = 1'b1;
								end
							end
						end
					end
					OP_RETURN: begin
						if (r.ret_valid) begin
							n.next_ptr  = r.ret_ptr;
							n.ret_valid = 1'b0;
							if (!c.from_prog) begin
								n.exec = EX_IDLE;
							end
						end else begin
							n.evt.warn = 1'b1;
						end
					end
					default: begin
						n.shift = 1'b0;
					end
				endcase
				// Halt and pause never replace the remembered command
				if ((c.op != OP_STOP) && (c.op != OP_PAUSE)) begin
					n.last_op = c.op;
				end
			end
		end

		// Register writes other than the command slot
		if (bus_wr) begin
			n.bresp = RESP_OK;
			if (is_stack(r.aw_addr)) begin
				if (!c.valid) begin
					n.stack[idx_w] = merge(r.stack[idx_w], r.w_data, r.w_strb);
				end
			end else begin
				case (r.aw_addr)
					OFS_CMD: begin
						n.bresp = RESP_OK;
					end
					OFS_STATUS: begin
						if (r.w_strb[0] && r.w_data[ST_WARN_BIT]) begin
							n.warn_sticky = 1'b0; // Write one to clear
						end
					end
					OFS_NEXT: begin
						if (r.w_strb[0] && (n.exec == EX_IDLE) && !c.valid) begin
							n.next_ptr = r.w_data[PTR_W-1:0];
						end
					end
					OFS_RETURN: begin
						if (!c.valid) begin
							n.ret_ptr   = r.w_data[PTR_W-1:0];
							n.ret_valid = r.w_data[RET_VALID_BIT];
						end
					end
					default: begin
						n.bresp = RESP_ERR;
					end
				endcase
			end
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
		end

		// Sticky warning: a new warning wins over a clear in the same cycle
		if (n.evt.warn) begin
			n.warn_sticky = 1'b1;
		end

		// AXI write channels, taken in either order
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_rdy && s_axi_awvalid) begin
			n.aw_got  = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (r.w_rdy && s_axi_wvalid) begin
			n.w_got  = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		n.aw_rdy = !n.aw_got;
		n.w_rdy  = !n.w_got;

		// AXI read channel, one outstanding read
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (r.ar_rdy && s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_word;
			n.rresp  = rd_hit ? RESP_OK : RESP_ERR;
		end
		n.ar_rdy = !n.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Everything clears to zero: idle state and an empty stack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign exec_state    = r.exec;
	assign next_ptr      = r.next_ptr;
	assign shift_ind     = r.shift;
	assign halted_in     = r.halted_in;
	assign halt_op       = r.halt_op;
	assign level_one     = r.stack[0];
	assign evt           = r.evt;
	assign s_axi_awready = r.aw_rdy;
	assign s_axi_wready  = r.w_rdy;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_arready = r.ar_rdy;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign s_axi_rvalid  = r.rvalid;

endmodule

// File: cpcs_core_asserts.sv
`timescale 1ns/1ps
module cpcs_core_asserts
	import cpcs_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire cpcs_cmd_type      cmd_in,
	input wire logic              cmd_busy,
	input wire logic              prog_stored,
	input wire logic              edit_at_end,
	input wire cpcs_exec_type     exec_state,
	input wire logic [PTR_W-1:0]  next_ptr,
	input wire logic              shift_ind,
	input wire logic              halted_in,
	input wire logic [DATA_W-1:0] level_one,
	input wire cpcs_evt_type      evt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Slot decode by origin; a shifted key runs its alternate instead, so it is left out
	logic dir;
	logic prg;
	assign dir = cmd_in.valid && !shift_ind && !cmd_in.from_prog;
	assign prg = cmd_in.valid && !shift_ind && cmd_in.from_prog;
	// A halt that must wait for the running command
	sequence halt_req_s;
		dir && cmd_in.op == OP_STOP && exec_state == EX_RUN && cmd_busy;
	endsequence
	sequence busy_ends_s;
		cmd_busy ##1 !cmd_busy;
	endsequence
	////////////////////////////////////////
	start_run_a: assert property (dir && cmd_in.op == OP_START && prog_stored
		|=> exec_state == EX_RUN && next_ptr == 8'h00) else $error("start did not run from zero");
	start_step_a: assert property (prg && cmd_in.op == OP_START && exec_state == EX_STEP
		|=> exec_state == EX_IDLE && next_ptr == 8'h00) else $error("stored start in step");
	start_loop_a: assert property (prg && cmd_in.op == OP_START && exec_state == EX_RUN
		|=> exec_state == EX_RUN && next_ptr == 8'h00) else $error("stored start in run");
	step_enter_a: assert property (dir && cmd_in.op == OP_STEP && exec_state == EX_IDLE && !edit_at_end
		|=> exec_state == EX_STEP && $stable(next_ptr)) else $error("step not entered");
	step_end_a: assert property (dir && cmd_in.op == OP_STEP && exec_state == EX_IDLE && edit_at_end
		|=> evt.warn && exec_state == EX_IDLE) else $error("step at end line");
	step_stored_a: assert property (prg && cmd_in.op == OP_STEP && exec_state == EX_IDLE
		|=> exec_state == EX_IDLE) else $error("stored step accepted");
	idle_halt_a: assert property (dir && cmd_in.op == OP_STOP && exec_state == EX_IDLE && !cmd_busy
		|=> evt.warn && exec_state == EX_IDLE) else $error("idle halt not warned");
	halt_abort_a: assert property (dir && cmd_in.op == OP_STOP
		|=> evt.abort_acq && evt.cancel_bus && evt.flush_buf) else $error("halt did not abort");
	halt_defer_a: assert property (halt_req_s |=> exec_state == EX_RUN)
		else $error("halt did not wait");
	halt_done_a: assert property (halt_req_s ##1 busy_ends_s |=> exec_state == EX_IDLE && halted_in)
		else $error("halt did not finish");
	shift_set_a: assert property (cmd_in.valid && cmd_in.op == OP_SHIFT |=> shift_ind)
		else $error("shift not set");
	shift_drop_a: assert property (cmd_in.valid && cmd_in.op != OP_SHIFT |=> !shift_ind)
		else $error("shift not cleared");
	alt_gate_a: assert property (evt.alt_valid |-> $past(shift_ind))
		else $error("alternate without shift");
	stack_zero_a: assert property (cmd_in.valid && !shift_ind && cmd_in.op == OP_CLEAR_STACK
		|=> level_one == RST_LEVEL) else $error("stack not cleared");
endmodule

bind cpcs_core cpcs_core_asserts i_chk (.clk(clk), .rst_n(rst_n), .cmd_in(cmd_in), .cmd_busy(cmd_busy),
	.prog_stored(prog_stored), .edit_at_end(edit_at_end), .exec_state(exec_state), .next_ptr(next_ptr),
	.shift_ind(shift_ind), .halted_in(halted_in), .level_one(level_one), .evt(evt));

// File: cpcs_keypad_model.sv
`timescale 1ns/1ps
module cpcs_keypad_model
	import cpcs_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   prog_stored,
	output cpcs_cmd_type cmd_in
);
	initial cmd_in = '0;
	// One command per slot; released data is inverted so stale values never look valid
	task automatic send(input cpcs_op_type op, input logic prog, input logic alt, input logic [DATA_W-1:0] d);
		cpcs_cmd_type c;
		c = '{valid: 1'b1, op: op, from_prog: prog, has_alt: alt, data: d};
		if (op == OP_START && !prog && !prog_stored) c.valid = 1'b0;
		@(posedge clk);
		cmd_in <= c;
		@(posedge clk);
		c.valid = 1'b0;
		c.data = ~d;
		cmd_in <= c;
		#1;
	endtask
endmodule

// File: cpcs_core_tb_top.sv
`timescale 1ns/1ps
module cpcs_core_tb_top
	import cpcs_pkg::*;
;
	logic              clk, rst_n, cmd_busy, prog_stored, edit_at_end, shift_ind, halted_in;
	logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, level_one, rd;
	logic [1:0]        bresp, rresp, rsp;
	logic [PTR_W-1:0]  next_ptr;
	cpcs_cmd_type      cmd_in;
	cpcs_exec_type     exec_state;
	cpcs_op_type       halt_op;
	cpcs_evt_type      evt;
	int                fail_count, tests_run;

	cpcs_core i_dut (.clk(clk), .rst_n(rst_n), .cmd_in(cmd_in), .cmd_busy(cmd_busy), .prog_stored(prog_stored),
		.edit_at_end(edit_at_end), .exec_state(exec_state), .next_ptr(next_ptr), .shift_ind(shift_ind),
		.halted_in(halted_in), .halt_op(halt_op), .level_one(level_one), .evt(evt), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cpcs_keypad_model i_kbd (.clk(clk), .prog_stored(prog_stored), .cmd_in(cmd_in));

	////////////////////////////////////////
	task automatic check(string name, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Bus master: each channel is released only at the edge that takes it
	// No cycle count is assumed for the answer; only the watchdog ends a hung wait
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic go(cpcs_op_type op, logic prog);
		i_kbd.send(op, prog, 1'b0, 32'h0000_0000);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < STACK_DEPTH; i++) begin
			rd_reg(OFS_STACK + ADDR_W'(4 * i), rd, rsp);
			check("stack level", rd, RST_LEVEL);
		end
		rd_reg(OFS_STATUS, rd, rsp);
		check("status", rd, 32'h0000_0000);
		rd_reg(8'h40, rd, rsp);
		check("unmapped read", rsp, RESP_ERR);
		wr(8'h40, 32'h0000_0001, rsp);
		check("unmapped write", rsp, RESP_ERR);
		wr(OFS_NEXT, 32'h0000_0007, rsp);
		check("next port", next_ptr, 8'h07);
		$display("reset test done");
	endtask
	// Every operation is judged on all five levels, so partial updates show
	task automatic t_stack;
		cpcs_op_type       ops [5] = '{OP_SWAP, OP_ROLL, OP_CLEAR_BOTTOM, OP_ENTER, OP_CLEAR_STACK};
		logic [DATA_W-1:0] e [STACK_DEPTH];
		logic [DATA_W-1:0] t;
		for (int i = 0; i < STACK_DEPTH; i++) begin
			e[i] = 32'h1111_1111 * (i + 1);
			wr(OFS_STACK + ADDR_W'(4 * i), e[i], rsp);
		end
		foreach (ops[k]) begin
			t = e[0];
			case (ops[k])
				OP_SWAP: begin
					e[0] = e[1];
					e[1] = t;
				end
				OP_ENTER: for (int i = 4; i > 0; i--) e[i] = e[i - 1];
				OP_CLEAR_STACK: e = '{default: '0};
				default: begin
					for (int i = 0; i < 4; i++) e[i] = e[i + 1];
					if (ops[k] == OP_ROLL) e[4] = t;
				end
			endcase
			go(ops[k], 1'b0);
			check("level one port", level_one, e[0]);
			for (int i = 0; i < STACK_DEPTH; i++) begin
				rd_reg(OFS_STACK + ADDR_W'(4 * i), rd, rsp);
				check("stack level", rd, e[i]);
			end
		end
		$display("stack test done");
	endtask
	task automatic t_run;
		wr(OFS_RETURN, 32'h8000_0005, rsp);
		go(OP_START, 1'b0);
		check("exec", exec_state, EX_RUN);
		check("next", next_ptr, 8'h00);
		rd_reg(OFS_RETURN, rd, rsp);
		check("return valid", rd[RET_VALID_BIT], 1'b0);
		go(OP_OTHER, 1'b1);
		wr(OFS_RETURN, 32'h8000_0009, rsp);
		go(OP_START, 1'b1);
		check("exec", exec_state, EX_RUN);
		check("next", next_ptr, 8'h00);
		rd_reg(OFS_RETURN, rd, rsp);
		check("return valid", rd[RET_VALID_BIT], 1'b0);
		go(OP_OTHER, 1'b1);
		@(posedge clk);
		cmd_busy <= 1'b1;
		go(OP_STOP, 1'b0);
		check("abort events", {evt.abort_acq, evt.cancel_bus, evt.flush_buf}, 3'b111);
		check("exec", exec_state, EX_RUN);
		@(posedge clk);
		cmd_busy <= 1'b0;
		@(posedge clk);
		#1;
		check("exec", exec_state, EX_IDLE);
		check("next", next_ptr, 8'h01);
		check("halted in", halted_in, 1'b1);
		check("halt op", halt_op, OP_OTHER);
		go(OP_START, 1'b0);
		go(OP_ACQUIRE, 1'b1);
		go(OP_PAUSE, 1'b1);
		go(OP_STOP, 1'b1);
		check("exec", exec_state, EX_IDLE);
		check("next", next_ptr, 8'h03);
		check("halt op", halt_op, OP_ACQUIRE);
		check("halted in", halted_in, 1'b1);
		// Return issued through the bus command slot, then again from the keypad with the register empty
		wr(OFS_RETURN, 32'h8000_0005, rsp);
		wr(OFS_CMD, DATA_W'(OP_RETURN), rsp);
		check("next", next_ptr, 8'h05);
		check("exec", exec_state, EX_IDLE);
		rd_reg(OFS_RETURN, rd, rsp);
		check("return valid", rd[RET_VALID_BIT], 1'b0);
		go(OP_RETURN, 1'b0);
		check("warn", evt.warn, 1'b1);
		$display("run test done");
	endtask
	task automatic t_step;
		go(OP_STEP, 1'b0);
		check("exec", exec_state, EX_STEP);
		check("next", next_ptr, 8'h05);
		go(OP_START, 1'b1);
		check("exec", exec_state, EX_IDLE);
		check("next", next_ptr, 8'h00);
		@(posedge clk);
		edit_at_end <= 1'b1;
		go(OP_STEP, 1'b0);
		check("warn", evt.warn, 1'b1);
		check("exec", exec_state, EX_IDLE);
		@(posedge clk);
		edit_at_end <= 1'b0;
		go(OP_STEP, 1'b1);
		check("exec", exec_state, EX_IDLE);
		go(OP_STOP, 1'b0);
		check("warn", evt.warn, 1'b1);
		check("exec", exec_state, EX_IDLE);
		$display("step test done");
	endtask
	task automatic t_shift;
		go(OP_SHIFT, 1'b0);
		check("shift", shift_ind, 1'b1);
		go(OP_CLEAR_SHIFT, 1'b0);
		check("shift", shift_ind, 1'b0);
		go(OP_SHIFT, 1'b0);
		i_kbd.send(OP_OTHER, 1'b0, 1'b1, 32'h0000_0000);
		check("alternate", {evt.alt_valid, evt.alt_op}, {1'b1, OP_OTHER});
		check("shift", shift_ind, 1'b0);
		i_kbd.send(OP_DIGIT, 1'b0, 1'b0, 32'h0000_00a5);
		go(OP_SHIFT, 1'b0);
		go(OP_SWAP, 1'b0);
		check("level one", level_one, 32'h0000_00a5);
		rd_reg(OFS_STATUS, rd, rsp);
		check("numeric", rd[ST_NUM_BIT], 1'b1);
		go(OP_RUN, 1'b0);
		check("exec", exec_state, EX_RUN);
		go(OP_STEP, 1'b0);
		go(OP_STOP, 1'b0);
		rd_reg(OFS_STATUS, rd, rsp);
		check("numeric", rd[ST_NUM_BIT], 1'b1);
		go(OP_ENTER, 1'b0);
		rd_reg(OFS_STATUS, rd, rsp);
		check("numeric", rd[ST_NUM_BIT], 1'b0);
		rd_reg(OFS_STACK + 8'h04, rd, rsp);
		check("level two", rd, 32'h0000_0000);
		$display("shift test done");
	endtask

	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard of 10000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#100us;
		fail_count++;
		$display("watchdog expired");
		report_and_stop();
	end
	initial begin
		{rst_n, cmd_busy, edit_at_end, awvalid, wvalid, bready, arvalid, rready} = '0;
		prog_stored = 1'b1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		fail_count = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_stack();
		t_run();
		t_step();
		t_shift();
		report_and_stop();
	end
endmodule
